// file: uic_pkg.sv
// Package with register offsets, field positions, codes and timing counts.
package uic_pkg;
   localparam logic [2:0] RXDATA_OFS  = 3'h0;
   localparam logic [2:0] ENABLE_OFS  = 3'h1;
   localparam logic [2:0] STATUS_OFS  = 3'h2;
   localparam logic [2:0] LINEST_OFS  = 3'h5;
   localparam logic [2:0] MODEMST_OFS = 3'h6;
   localparam int IE_RX    = 0;
   localparam int IE_TX    = 1;
   localparam int IE_LS    = 2;
   localparam int IE_MS    = 3;
   localparam int IE_XOFF  = 5;
   localparam int IE_RTS   = 6;
   localparam int IE_CTS   = 7;
   localparam int FC_EN    = 0;
   localparam int FC_RXRST = 1;
   localparam int FC_TXRST = 2;
   localparam logic [7:0] ENABLE_RESET   = 8'h00;
   localparam logic [7:0] ENABLE_LOWMASK = 8'h0f;
   localparam logic [5:0] CODE_LS   = 6'h06;
   localparam logic [5:0] CODE_TO   = 6'h0c;
   localparam logic [5:0] CODE_RX   = 6'h04;
   localparam logic [5:0] CODE_TX   = 6'h02;
   localparam logic [5:0] CODE_MS   = 6'h00;
   localparam logic [5:0] CODE_XOFF = 6'h10;
   localparam logic [5:0] CODE_FLOW = 6'h20;
   localparam logic [5:0] CODE_NONE = 6'h01;
   localparam logic [6:0] TO_CHARS  = 7'h04;
   localparam logic [6:0] TO_BITS   = 7'h0c;
endpackage : uic_pkg

// file: uart_interrupt_fifo_control.sv
// Interrupt enable, prioritised status and FIFO control for one channel.
`timescale 1ns/10ps

//  Operation
// - FIFOs on with enables 0..3 clear gives polled use through line status.
// - Line status byte packs ready, overrun, head errors, empties, FIFO error.
// - Enable 0 raises receive ready on held character or trigger level.
// - Enable 1 raises transmit ready on empty or below trigger, also on enable.
// - Overrun interrupts at once; other errors at readout or at once if set.
// - Enable 3 raises modem status when any modem delta bit 0..3 is set.
// - Enable bits 4..7 writable only with enhanced enable; all reset zero.
// - Rising edge of RTS or CTS under auto flow control interrupts.
// - Status read returns only the top pending source; others wait.
// - Time-out after four characters plus twelve bits; cleared by data read.
// - Transmit ready from trigger or empty FIFO; transmitter empty in RS-485.
// - Wake-up set on sleep exit, cleared by status read, code 000001.
// - Each source clears by its own read or write action.
// - Xoff, special and flow-change flags clear as described.
// - Codes for priorities 1 to 4 are 06, 0c, 04 and 02.
// - Codes for priorities 5 to 7 are 00, 10, 20; none is 01.
// - Status bit 0 is zero while pending, one when idle or woken.
// - Status bits 4 and 5 only active under their enables.
// - Status bits 7:6 mirror the FIFO enable.
// - FIFO control bit 0 enables FIFOs; other bits need bit 0 set.
// - Bits 1 and 2 pulse receive and transmit FIFO resets, self-clearing.
module uart_interrupt_fifo_control (
   input  wire logic       core_clk,      // Core clock, 40 MHz.
   input  wire logic       rst_n,         // Synchronous reset, active low.
   input  wire logic [2:0] regAddr,       // Register address.
   input  wire logic       regRd,         // Read strobe, one cycle.
   input  wire logic       regWr,         // Write strobe, one cycle.
   input  wire logic [7:0] regWdata,      // Write data.
   output logic      [7:0] regRdata,      // Read data, next cycle.
   input  wire logic       enhancedEn,    // Enhanced-function enable bit.
   input  wire logic       errImmediate,  // Extended modem status bit 6.
   input  wire logic       rxDataReady,   // Receive data present.
   input  wire logic       rxCharIn,      // Pulse: character received.
   input  wire logic [2:0] rxErrIn,       // Errors of incoming character.
   input  wire logic [2:0] rxErrHead,     // Errors of head character.
   input  wire logic       rxOverrun,     // Overrun status level.
   input  wire logic       rxOverrunEv,   // Pulse: overrun happened.
   input  wire logic       rxFifoErr,     // Error somewhere in receive FIFO.
   input  wire logic       rxTrigger,     // Receive level at or above trigger.
   input  wire logic       bitTick,       // Pulse: one bit time elapsed.
   input  wire logic [3:0] charBits,      // Bits per character frame.
   input  wire logic       txHoldEmpty,   // Transmit holding empty.
   input  wire logic       txBelowTrig,   // Transmit level below trigger.
   input  wire logic       txFifoEmpty,   // Transmit FIFO empty.
   input  wire logic       txAllEmpty,    // FIFO and shifter both empty.
   input  wire logic       rs485Auto,     // Auto RS-485 direction control.
   input  wire logic [3:0] modemDelta,    // Modem status bits 0..3.
   input  wire logic [7:0] modemStatus,   // Modem status byte for reads.
   input  wire logic       xoffDetect,    // Pulse: Xoff received.
   input  wire logic       xonDetect,     // Pulse: Xon received.
   input  wire logic       specialDetect, // Pulse: special character seen.
   input  wire logic       autoRts,       // Auto RTS flow control on.
   input  wire logic       autoCts,       // Auto CTS flow control on.
   input  wire logic       rtsOut,        // RTS# pin level.
   input  wire logic       ctsIn,         // CTS# pin level.
   input  wire logic       sleepExit,     // Pulse: left sleep mode.
   output logic            intOut,        // Interrupt request, active high.
   output logic      [7:0] intEnable,     // Enable register contents.
   output logic            fifoEnable,    // FIFOs enabled.
   output logic            rxFifoReset,   // Pulse: reset receive FIFO.
   output logic            txFifoReset,   // Pulse: reset transmit FIFO.
   output logic            lineStReadPulse,  // Pulse: line status was read.
   output logic            modemStReadPulse  // Pulse: modem status was read.
);

   typedef struct packed {
      logic [7:0] intEn;
      logic       fifoEn;
      logic       rxRst;
      logic       txRst;
      logic       lsPend;
      logic       toPend;
      logic [6:0] toCnt;
      logic       txPend;
      logic       txCondPrev;
      logic       xoffPend;
      logic       specPend;
      logic       flowPend;
      logic       rtsPrev;
      logic       ctsPrev;
      logic       wakePend;
      logic [7:0] rdData;
      logic       irq;
      logic       lineStRd;
      logic       modemStRd;
   } uic_state_t;

   uic_state_t st;
   uic_state_t next_st;

   // Highest-priority code among the pending, enabled sources.
   function automatic logic [5:0] uic_code(input logic [6:0] p);
      if (p[0])      uic_code = uic_pkg::CODE_LS;
      else if (p[1]) uic_code = uic_pkg::CODE_TO;
      else if (p[2]) uic_code = uic_pkg::CODE_RX;
      else if (p[3]) uic_code = uic_pkg::CODE_TX;
      else if (p[4]) uic_code = uic_pkg::CODE_MS;
      else if (p[5]) uic_code = uic_pkg::CODE_XOFF;
      else if (p[6]) uic_code = uic_pkg::CODE_FLOW;
      else           uic_code = uic_pkg::CODE_NONE;
   endfunction : uic_code

   logic [6:0] pend;
   logic [5:0] code;
   logic       rxLevel;
   logic       txCond;
   logic [6:0] toLimit;
   logic       rdStatus;
   logic       rdRxData;
   logic       rdLineSt;
   logic       rdModemSt;
   logic       wrTxData;

   always_comb begin
      rdStatus  = regRd && (regAddr == uic_pkg::STATUS_OFS);
      rdRxData  = regRd && (regAddr == uic_pkg::RXDATA_OFS);
      rdLineSt  = regRd && (regAddr == uic_pkg::LINEST_OFS);
      rdModemSt = regRd && (regAddr == uic_pkg::MODEMST_OFS);
      wrTxData  = regWr && (regAddr == uic_pkg::RXDATA_OFS);
      rxLevel = st.fifoEn ? rxTrigger : rxDataReady;
      if (rs485Auto)
         txCond = txAllEmpty;
      else if (st.fifoEn)
         txCond = txBelowTrig || txFifoEmpty;
      else
         txCond = txHoldEmpty;
      toLimit = 7'(uic_pkg::TO_CHARS * 7'(charBits)) + uic_pkg::TO_BITS;
      pend[0] = st.intEn[uic_pkg::IE_LS] && st.lsPend;
      pend[1] = st.intEn[uic_pkg::IE_RX] && st.toPend;
      pend[2] = st.intEn[uic_pkg::IE_RX] && rxLevel;
      pend[3] = st.intEn[uic_pkg::IE_TX] && st.txPend;
      pend[4] = st.intEn[uic_pkg::IE_MS] && (|modemDelta);
      pend[5] = st.intEn[uic_pkg::IE_XOFF] && (st.xoffPend || st.specPend);
      pend[6] = (st.intEn[uic_pkg::IE_RTS] || st.intEn[uic_pkg::IE_CTS])
                && st.flowPend;
      code    = uic_code(pend);
   end

   always_comb begin
      next_st       = st;
      next_st.rxRst = 1'b0;
      next_st.txRst = 1'b0;
      next_st.lineStRd  = rdLineSt;
      next_st.modemStRd = rdModemSt;
      next_st.rtsPrev    = rtsOut;
      next_st.ctsPrev    = ctsIn;
      next_st.txCondPrev = txCond;

      // Register writes.
      if (regWr && regAddr == uic_pkg::ENABLE_OFS) begin
         if (enhancedEn)
            next_st.intEn = regWdata;
         else
            next_st.intEn = (st.intEn & ~uic_pkg::ENABLE_LOWMASK)
                            | (regWdata & uic_pkg::ENABLE_LOWMASK);
      end
      if (regWr && regAddr == uic_pkg::STATUS_OFS) begin
         next_st.fifoEn = regWdata[uic_pkg::FC_EN];
         if (regWdata[uic_pkg::FC_EN]) begin
            next_st.rxRst = regWdata[uic_pkg::FC_RXRST];
            next_st.txRst = regWdata[uic_pkg::FC_TXRST];
         end
      end

      // Clears come first so that a same-cycle set below wins.
      if (rdLineSt)
         next_st.lsPend = 1'b0;
      if (rdStatus && code == uic_pkg::CODE_TX)
         next_st.txPend = 1'b0;
      if (wrTxData)
         next_st.txPend = 1'b0;
      if ((rdStatus && code == uic_pkg::CODE_XOFF) || xonDetect)
         next_st.xoffPend = 1'b0;
      if ((rdStatus && code == uic_pkg::CODE_XOFF) || rxCharIn)
         next_st.specPend = 1'b0;
      if (rdModemSt)
         next_st.flowPend = 1'b0;
      if (rdStatus && code == uic_pkg::CODE_NONE)
         next_st.wakePend = 1'b0;
      if (rdRxData)
         next_st.toPend = 1'b0;

      // Sets.
      if (rxOverrunEv)
         next_st.lsPend = 1'b1;
      if (errImmediate && rxCharIn && (|rxErrIn))
         next_st.lsPend = 1'b1;
      if (!errImmediate && rdRxData && (|rxErrHead))
         next_st.lsPend = 1'b1;
      if (txCond && !st.txCondPrev)
         next_st.txPend = 1'b1;
      // Turning the enable on while txCond holds (holding empty, FIFO below trigger or empty, transmitter empty in RS-485) interrupts.
      if (regWr && regAddr == uic_pkg::ENABLE_OFS && regWdata[uic_pkg::IE_TX]
          && !st.intEn[uic_pkg::IE_TX] && txCond)
         next_st.txPend = 1'b1;
      if (xoffDetect)
         next_st.xoffPend = 1'b1;
      if (specialDetect)
         next_st.specPend = 1'b1;
      if ((autoRts && rtsOut && !st.rtsPrev)
          || (autoCts && ctsIn && !st.ctsPrev))
         next_st.flowPend = 1'b1;
      if (sleepExit)
         next_st.wakePend = 1'b1;

      // The timer restarts on every arrival or read and only runs with data.
      if (!st.fifoEn || !rxDataReady || rxCharIn || rdRxData)
         next_st.toCnt = 7'h00;
      else if (bitTick && st.toCnt != toLimit)
         next_st.toCnt = 7'(st.toCnt + 7'h01);
      if (st.fifoEn && bitTick && st.toCnt == 7'(toLimit - 7'h01)
          && !rxCharIn && !rdRxData && rxDataReady)
         next_st.toPend = 1'b1;

      // Read data is registered; status is sampled on the read edge.
      next_st.rdData = 8'h00;
      if (regRd) begin
         case (regAddr)
            uic_pkg::ENABLE_OFS: next_st.rdData = st.intEn;
            uic_pkg::STATUS_OFS: next_st.rdData = {st.fifoEn, st.fifoEn, code};
            uic_pkg::LINEST_OFS: next_st.rdData = {rxFifoErr, txAllEmpty,
                                  txHoldEmpty, rxErrHead, rxOverrun,
                                  rxDataReady};
            uic_pkg::MODEMST_OFS: next_st.rdData = modemStatus;
            default:          next_st.rdData = 8'h00;
         endcase
      end
      next_st.irq = (|pend) || st.wakePend;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign regRdata     = st.rdData;
   assign intOut       = st.irq;
   assign intEnable        = st.intEn;
   assign fifoEnable       = st.fifoEn;
   assign rxFifoReset      = st.rxRst;
   assign txFifoReset      = st.txRst;
   assign lineStReadPulse  = st.lineStRd;
   assign modemStReadPulse = st.modemStRd;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_status_read;
      regRd && regAddr == uic_pkg::STATUS_OFS;
   endsequence

   a_status_fifo_bits: assert property (
      s_status_read |=> regRdata[7:6] == {2{fifoEnable}})
      else $error("status bits 7:6 do not follow FIFO enable");
   a_status_idle_code: assert property (
      s_status_read ##0 (pend == 7'h00) |=> regRdata[5:0] == 6'h01)
      else $error("idle status code wrong");
   a_status_ls_top: assert property (
      s_status_read ##0 pend[0] |=> regRdata[5:0] == 6'h06)
      else $error("line status not reported first");
   a_status_flow_code: assert property (
      s_status_read ##0 (pend == 7'h40) |=> regRdata[5:0] == 6'h20)
      else $error("flow change code wrong");
   a_enable_high_lock: assert property (
      regWr && regAddr == uic_pkg::ENABLE_OFS && !enhancedEn
      |=> intEnable[7:4] == $past(intEnable[7:4]))
      else $error("high enable bits written without enhanced enable");
   a_fifo_reset_pulse: assert property (
      rxFifoReset |=> !rxFifoReset)
      else $error("receive FIFO reset did not self-clear");
   a_fifo_ctl_gate: assert property (
      regWr && regAddr == uic_pkg::STATUS_OFS && !regWdata[0]
      |=> !rxFifoReset && !txFifoReset && !fifoEnable)
      else $error("FIFO control bits acted without bit 0");
   a_irq_follows: assert property (
      (|pend) |=> intOut)
      else $error("interrupt output missing while pending");
   a_line_clear: assert property (
      regRd && regAddr == uic_pkg::LINEST_OFS && !rxOverrunEv && !rxCharIn
      && !(rdRxData) |=> !st.lsPend)
      else $error("line status pending not cleared by read");
   a_tx_enable_set: assert property (
      regWr && regAddr == uic_pkg::ENABLE_OFS && regWdata[1]
      && !intEnable[1] && txCond |=> st.txPend ##1 intOut)
      else $error("enabling transmit ready over empty register missed");

endmodule : uart_interrupt_fifo_control

// file: uic_host_model.sv
// Host processor model that runs register cycles on the parallel bus.
`timescale 1ns/10ps
module uic_host_model (
   input  wire logic       core_clk, // Core clock.
   input  wire logic [7:0] regRdata, // Read data from the block.
   output logic      [2:0] regAddr,  // Register address.
   output logic            regRd,    // Read strobe.
   output logic            regWr,    // Write strobe.
   output logic      [7:0] regWdata  // Write data.
);
   initial begin
      regAddr  = 3'h0;
      regRd    = 1'b0;
      regWr    = 1'b0;
      regWdata = 8'h00;
   end
   // Write data is inverted once released so stale values never match.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge core_clk);
      regWr    <= 1'b0;
      regWdata <= ~d;
   endtask : wr
   // The answer is registered at the taking edge, so it is read just after.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge core_clk);
      regRd   <= 1'b0;
      #1 d = regRdata;
   endtask : rd
endmodule : uic_host_model

// file: uart_interrupt_fifo_control_tb_top.sv
// Self-checking testbench for the interrupt and FIFO control block.
`timescale 1ns/10ps
module uart_interrupt_fifo_control_tb_top;
   logic       core_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [2:0] regAddr;
   logic       regRd, regWr, intOut, fifoEnable, rxFifoReset, txFifoReset;
   logic       lineStReadPulse, modemStReadPulse;
   logic [7:0] regWdata, regRdata, intEnable, modemStatus = 8'h5a;
   logic       enhancedEn = 0, errImmediate = 0, rxDataReady = 0;
   logic       rxCharIn = 0, rxOverrun = 0, rxOverrunEv = 0, rxFifoErr = 0;
   logic       rxTrigger = 0, bitTick = 0, txHoldEmpty = 0, txBelowTrig = 0;
   logic       txFifoEmpty = 0, txAllEmpty = 0, rs485Auto = 0;
   logic       xoffDetect = 0, xonDetect = 0, specialDetect = 0;
   logic       autoRts = 0, autoCts = 0, rtsOut = 0, ctsIn = 0;
   logic       sleepExit = 0;
   logic [2:0] rxErrIn = 3'h0, rxErrHead = 3'h0;
   logic [3:0] charBits = 4'h8, modemDelta = 4'h0;
   logic [7:0] d;
   int         error_cnt = 0, compares = 0, cyc = 0;

   always #12.5 core_clk = ~core_clk;

   uic_host_model uic_host_model_i (.core_clk(core_clk),
      .regRdata(regRdata), .regAddr(regAddr), .regRd(regRd),
      .regWr(regWr), .regWdata(regWdata));

   uart_interrupt_fifo_control uart_interrupt_fifo_control_i (.*);

   task conclude;
      if (error_cnt == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   task chk(input logic [7:0] g, input logic [7:0] e, input string m);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task st(input logic [7:0] e);
      uic_host_model_i.rd(uic_pkg::STATUS_OFS, d);
      chk(d, e, "status");
   endtask : st

   task tk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tk

   task t_reset;
      chk(intEnable, 8'h00, "enable reset");
      chk({7'h0, intOut}, 8'h00, "int reset");
      st(8'h01);
   endtask : t_reset

   task t_fifo;
      uic_host_model_i.wr(uic_pkg::STATUS_OFS, 8'h07);
      #1 chk({fifoEnable, rxFifoReset, txFifoReset}, 8'h07, "fc");
      tk(1);
      chk({rxFifoReset, txFifoReset}, 8'h00, "fc self clear");
      st(8'hc1);
      uic_host_model_i.wr(uic_pkg::STATUS_OFS, 8'h06);
      #1 chk({fifoEnable, rxFifoReset, txFifoReset}, 8'h00, "fc off");
      st(8'h01);
      uic_host_model_i.wr(uic_pkg::STATUS_OFS, 8'h01);
      #1 chk({fifoEnable, rxFifoReset, txFifoReset}, 8'h04, "fc on");
   endtask : t_fifo

   task t_enable;
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'hff);
      #1 chk(intEnable, 8'h0f, "upper locked");
      @(posedge core_clk) enhancedEn <= 1'b1;
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'hf0);
      #1 chk(intEnable, 8'hf0, "upper open");
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'h00);
      st(8'hc1);
   endtask : t_enable

   task t_tx_prio;
      // FIFOs are on here, so the empty transmit FIFO is what counts.
      @(posedge core_clk) {txHoldEmpty, txFifoEmpty} <= 2'h3;
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'h02);
      tk(3);
      chk({7'h0, intOut}, 8'h01, "tx int");
      st(8'hc2);
      tk(2);
      chk({7'h0, intOut}, 8'h00, "tx cleared");
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'h07);
      @(posedge core_clk);
      {rxTrigger, rxDataReady, rxFifoErr, rxErrHead} <= 6'h3d;
      rxOverrunEv <= 1'b1;
      @(posedge core_clk) rxOverrunEv <= 1'b0;
      tk(2);
      st(8'hc6);
      uic_host_model_i.rd(uic_pkg::LINEST_OFS, d);
      chk(d, 8'hb5, "line status");
      chk({7'h0, lineStReadPulse}, 8'h01, "line read pulse");
      st(8'hc4);
      @(posedge core_clk);
      {rxTrigger, rxDataReady, rxFifoErr, rxErrHead} <= 6'h00;
      tk(3);
      st(8'hc1);
      chk({7'h0, intOut}, 8'h00, "all clear");
   endtask : t_tx_prio

   task t_modem_flow;
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'ha8);
      @(posedge core_clk) modemDelta <= 4'h2;
      tk(3);
      st(8'hc0);
      uic_host_model_i.rd(uic_pkg::MODEMST_OFS, d);
      chk(d, 8'h5a, "modem read");
      chk({7'h0, modemStReadPulse}, 8'h01, "modem read pulse");
      @(posedge core_clk) modemDelta <= 4'h0;
      @(posedge core_clk) {autoCts, ctsIn} <= 2'h3;
      tk(3);
      st(8'he0);
      uic_host_model_i.rd(uic_pkg::MODEMST_OFS, d);
      @(posedge core_clk) xoffDetect <= 1'b1;
      @(posedge core_clk) xoffDetect <= 1'b0;
      tk(2);
      st(8'hd0);
      // The status read cleared the first Xoff; raise a second one for Xon.
      @(posedge core_clk) xoffDetect <= 1'b1;
      @(posedge core_clk) xoffDetect <= 1'b0;
      tk(2);
      chk({7'h0, intOut}, 8'h01, "xoff again");
      @(posedge core_clk) xonDetect <= 1'b1;
      @(posedge core_clk) xonDetect <= 1'b0;
      tk(2);
      st(8'hc1);
   endtask : t_modem_flow

   task t_wake_timeout;
      @(posedge core_clk) sleepExit <= 1'b1;
      @(posedge core_clk) sleepExit <= 1'b0;
      tk(2);
      chk({7'h0, intOut}, 8'h01, "wake int");
      st(8'hc1);
      tk(2);
      chk({7'h0, intOut}, 8'h00, "wake clear");
      uic_host_model_i.wr(uic_pkg::ENABLE_OFS, 8'h01);
      @(posedge core_clk) rxDataReady <= 1'b1;
      // Eight-bit frames give a limit of 4 * 8 + 12 = 44 bit times.
      repeat (42) begin
         @(posedge core_clk) bitTick <= 1'b1;
         @(posedge core_clk) bitTick <= 1'b0;
      end
      st(8'hc1);
      repeat (4) begin
         @(posedge core_clk) bitTick <= 1'b1;
         @(posedge core_clk) bitTick <= 1'b0;
      end
      tk(2);
      st(8'hcc);
      uic_host_model_i.rd(uic_pkg::RXDATA_OFS, d);
      st(8'hc1);
   endtask : t_wake_timeout

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         conclude();
      end
   end

   initial begin
      tk(3);
      @(posedge core_clk) rst_n <= 1'b1;
      tk(1);
      t_reset();
      t_fifo();
      t_enable();
      t_tx_prio();
      t_modem_flow();
      t_wake_timeout();
      conclude();
   end
endmodule : uart_interrupt_fifo_control_tb_top
